// File: rtl/mq_pkg.sv
// Shared constants and types for the multi-queue port select block
`default_nettype none
package mq_pkg;
    localparam int NUM_Q = 32;
    localparam int QW = 5;
    localparam int DW = 36;
    localparam int ABUS_W = 8;
    localparam int ID_W = 3;
    localparam int ID_LSB = 5;
    localparam int QUAD_W = 2;
    localparam int FLAG_W = 8;
    localparam int SLOT_W = 4;
    localparam int QDEPTH = 16;
    localparam int PTR_W = 5;
    localparam int MEM_AW = 9;
    localparam int OUT_DEPTH = 4;
    localparam int OCC_W = 3;
    localparam int THR_W = 4;
    localparam logic [PTR_W-1:0] QDEPTH_LVL = 5'h10;
    localparam logic [OCC_W-1:0] OUT_DEPTH_LVL = 3'h4;
    localparam logic [THR_W-1:0] THR_RST = 4'h2;
    // AXI4-Lite register map
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] REG_THRESH = 8'h00;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Status register fields
    localparam int ST_WQ_LSB = 0;
    localparam int ST_RQ_LSB = 8;
    localparam int ST_NULL_BIT = 13;
    localparam int ST_FULL_BIT = 16;
    localparam int ST_VALID_BIT = 17;
    localparam int ST_WCHG_LSB = 20;
    localparam int ST_RCHG_LSB = 24;
    localparam int ST_OCC_LSB = 28;
    // Queue change sequence: select edge, then two more edges
    typedef enum logic [1:0] {
        CHG_IDLE = 2'b00,
        CHG_WAIT = 2'b01,
        CHG_SWAP = 2'b10
    } chg_state_t;
    typedef struct packed {
        logic [QW-1:0] queue;
        logic [DW-1:0] data;
    } rd_word_t;
endpackage
`default_nettype wire

// File: rtl/queue_mem.sv
// Shared word store for all queues, registered read data
`default_nettype none
module queue_mem #(
    parameter int AW = 9,
    parameter int DW = 36
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (re)
        begin
            rdata <= mem[raddr];
        end
    end
endmodule // queue_mem
`default_nettype wire

// File: rtl/out_fifo.sv
// Small valid/ready FIFO in the read data path
`default_nettype none
module out_fifo #(
    parameter int WIDTH = 41,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] buf_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = buf_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            buf_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r <= push ? PW'(wp_r + 1'b1) : wp_r;
            rp_r <= pop ? PW'(rp_r + 1'b1) : rp_r;
            cnt_r <= (PW+1)'(cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
        end
    end
endmodule // out_fifo
`default_nettype wire

// File: rtl/multi_queue_port_select.sv
// Queue select, write and read ports of a 32-queue flow-control store
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`default_nettype none
module multi_queue_port_select (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [mq_pkg::ID_W-1:0] device_identity_pins,
    input wire logic [mq_pkg::DW-1:0] write_data,
    input wire logic write_en_n,
    input wire logic write_addr_latch_en,
    input wire logic write_flag_strobe,
    input wire logic [mq_pkg::ABUS_W-1:0] write_queue_addr_bus,
    output logic queue_full_n,
    output logic [mq_pkg::FLAG_W-1:0] almost_full_bus,
    input wire logic read_en_n,
    input wire logic read_addr_latch_en,
    input wire logic read_flag_strobe,
    input wire logic [mq_pkg::ABUS_W-1:0] read_queue_addr_bus,
    input wire logic output_enable_n,
    output logic [mq_pkg::DW-1:0] read_data,
    output logic read_data_oe_n,
    output logic output_valid_n,
    output logic [mq_pkg::FLAG_W-1:0] almost_empty_bus,
    input wire logic [mq_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [mq_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Identity strap synchroniser
    logic [mq_pkg::ID_W-1:0] id_meta_r;
    logic [mq_pkg::ID_W-1:0] id_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            id_meta_r <= '0;
            id_r <= '0;
        end
        else
        begin
            id_meta_r <= device_identity_pins;
            id_r <= id_meta_r;
        end
    end

    // Per-queue pointers
    logic [mq_pkg::PTR_W-1:0] wptr_r [mq_pkg::NUM_Q];
    logic [mq_pkg::PTR_W-1:0] rptr_r [mq_pkg::NUM_Q];
    logic [mq_pkg::THR_W-1:0] thr_r;

    // Write address decode
    logic w_dev_hit;
    logic w_qsel;
    logic w_quad_sel;
    assign w_dev_hit = (write_queue_addr_bus[mq_pkg::ABUS_W-1:mq_pkg::ID_LSB] == id_r);
    assign w_qsel = write_addr_latch_en && !write_flag_strobe && w_dev_hit;
    assign w_quad_sel = !write_addr_latch_en && write_flag_strobe && w_dev_hit;

    // Write queue change sequence
    mq_pkg::chg_state_t wchg_r;
    logic [mq_pkg::QW-1:0] wq_cur_r;
    logic [mq_pkg::QW-1:0] wq_pend_r;
    logic [mq_pkg::QUAD_W-1:0] wquad_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wchg_r <= mq_pkg::CHG_IDLE;
            wq_cur_r <= '0;
            wq_pend_r <= '0;
        end
        else if (w_qsel)
        begin
            wchg_r <= mq_pkg::CHG_WAIT;
            wq_pend_r <= write_queue_addr_bus[mq_pkg::QW-1:0];
        end
        else
        begin
            case (wchg_r)
                mq_pkg::CHG_IDLE: wchg_r <= mq_pkg::CHG_IDLE;
                mq_pkg::CHG_WAIT: wchg_r <= mq_pkg::CHG_SWAP;
                mq_pkg::CHG_SWAP:
                begin
                    wchg_r <= mq_pkg::CHG_IDLE;
                    wq_cur_r <= wq_pend_r;
                end
                default: wchg_r <= mq_pkg::CHG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wquad_r <= '0;
        end
        else if (w_quad_sel)
        begin
            wquad_r <= write_queue_addr_bus[mq_pkg::QUAD_W-1:0];
        end
    end

    // Write acceptance into the current queue
    logic [mq_pkg::PTR_W-1:0] w_level;
    logic w_full;
    logic w_do;
    assign w_level = mq_pkg::PTR_W'(wptr_r[wq_cur_r] - rptr_r[wq_cur_r]);
    assign w_full = (w_level == mq_pkg::QDEPTH_LVL);
    assign w_do = !write_en_n && !w_full;
    assign queue_full_n = !w_full;

    // Read address decode
    logic r_dev_hit;
    logic r_qsel;
    logic r_null_sel;
    logic r_quad_sel;
    assign r_dev_hit = (read_queue_addr_bus[mq_pkg::ABUS_W-1:mq_pkg::ID_LSB] == id_r);
    assign r_qsel = read_addr_latch_en && !read_flag_strobe && r_dev_hit;
    assign r_null_sel = read_addr_latch_en && read_flag_strobe;
    assign r_quad_sel = !read_addr_latch_en && read_flag_strobe && r_dev_hit;

    // Read queue change sequence
    mq_pkg::chg_state_t rchg_r;
    logic [mq_pkg::QW-1:0] rq_cur_r;
    logic [mq_pkg::QW-1:0] rq_pend_r;
    logic rq_null_r;
    logic rq_null_pend_r;
    logic [mq_pkg::QUAD_W-1:0] rquad_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rchg_r <= mq_pkg::CHG_IDLE;
            rq_cur_r <= '0;
            rq_pend_r <= '0;
            rq_null_r <= 1'b0;
            rq_null_pend_r <= 1'b0;
        end
        else if (r_qsel || r_null_sel)
        begin
            rchg_r <= mq_pkg::CHG_WAIT;
            rq_pend_r <= r_qsel ? read_queue_addr_bus[mq_pkg::QW-1:0] : rq_pend_r;
            rq_null_pend_r <= r_null_sel;
        end
        else
        begin
            case (rchg_r)
                mq_pkg::CHG_IDLE: rchg_r <= mq_pkg::CHG_IDLE;
                mq_pkg::CHG_WAIT: rchg_r <= mq_pkg::CHG_SWAP;
                mq_pkg::CHG_SWAP:
                begin
                    rchg_r <= mq_pkg::CHG_IDLE;
                    rq_cur_r <= rq_pend_r;
                    rq_null_r <= rq_null_pend_r;
                end
                default: rchg_r <= mq_pkg::CHG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rquad_r <= '0;
        end
        else if (r_quad_sel)
        begin
            rquad_r <= read_queue_addr_bus[mq_pkg::QUAD_W-1:0];
        end
    end

    // Prefetch from the store into the output pipeline
    logic r_empty;
    logic r_pop;
    logic mem_vld_r;
    logic [mq_pkg::QW-1:0] mem_q_r;
    logic [mq_pkg::DW-1:0] mem_rdata;
    logic [mq_pkg::OCC_W-1:0] occ_r;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_take;
    mq_pkg::rd_word_t fifo_in;
    mq_pkg::rd_word_t fifo_out;
    logic out_valid_r;
    logic out_take;

    assign r_empty = rq_null_r || (wptr_r[rq_cur_r] == rptr_r[rq_cur_r]);
    // During a change the old queue is popped only while the read enable (read_en_n low) is active
    assign r_pop = !r_empty && fifo_in_ready && (occ_r < mq_pkg::OUT_DEPTH_LVL)
        && ((rchg_r == mq_pkg::CHG_IDLE) || !read_en_n);
    assign out_take = !read_en_n && out_valid_r;
    assign fifo_take = fifo_out_valid && (!out_valid_r || out_take);
    assign fifo_in.queue = mem_q_r;
    assign fifo_in.data = mem_rdata;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mem_vld_r <= 1'b0;
            mem_q_r <= '0;
            occ_r <= '0;
        end
        else
        begin
            mem_vld_r <= r_pop;
            mem_q_r <= rq_cur_r;
            occ_r <= mq_pkg::OCC_W'(occ_r + {2'h0, r_pop} - {2'h0, fifo_take});
        end
    end

    queue_mem #(
        .AW(mq_pkg::MEM_AW),
        .DW(mq_pkg::DW)
    ) u_mem (
        .clk(clk),
        .we(w_do),
        .waddr({wq_cur_r, wptr_r[wq_cur_r][mq_pkg::SLOT_W-1:0]}),
        .wdata(write_data),
        .re(r_pop),
        .raddr({rq_cur_r, rptr_r[rq_cur_r][mq_pkg::SLOT_W-1:0]}),
        .rdata(mem_rdata)
    );

    out_fifo #(
        .WIDTH($bits(mq_pkg::rd_word_t)),
        .DEPTH(mq_pkg::OUT_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(mem_vld_r),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_take),
        .out_data(fifo_out)
    );

    // Pointer updates, one generate entry per queue
    genvar gq;
    generate
        for (gq = 0; gq < mq_pkg::NUM_Q; gq++)
        begin : g_ptr
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    wptr_r[gq] <= '0;
                    rptr_r[gq] <= '0;
                end
                else
                begin
                    if (w_do && (wq_cur_r == mq_pkg::QW'(gq)))
                    begin
                        wptr_r[gq] <= mq_pkg::PTR_W'(wptr_r[gq] + 1'b1);
                    end
                    if (r_pop && (rq_cur_r == mq_pkg::QW'(gq)))
                    begin
                        rptr_r[gq] <= mq_pkg::PTR_W'(rptr_r[gq] + 1'b1);
                    end
                end
            end
        end
    endgenerate

    // Output register and valid flag
    logic [mq_pkg::DW-1:0] dout_r;
    logic oe_n_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            dout_r <= '0;
            out_valid_r <= 1'b0;
        end
        else if (fifo_take)
        begin
            dout_r <= fifo_out.data;
            out_valid_r <= 1'b1;
        end
        else if (out_take)
        begin
            out_valid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            oe_n_r <= 1'b1;
        end
        else
        begin
            oe_n_r <= output_enable_n;
        end
    end

    assign read_data = dout_r;
    assign read_data_oe_n = oe_n_r;
    assign output_valid_n = !out_valid_r;

    // Almost flag buses, one generate entry per flag bit
    logic [mq_pkg::FLAG_W-1:0] af_r;
    logic [mq_pkg::FLAG_W-1:0] ae_r;
    genvar gf;
    generate
        for (gf = 0; gf < mq_pkg::FLAG_W; gf++)
        begin : g_flag
            logic [mq_pkg::QW-1:0] fq_w;
            logic [mq_pkg::QW-1:0] fq_r;
            logic [mq_pkg::PTR_W-1:0] lvl_w;
            logic [mq_pkg::PTR_W-1:0] lvl_r;
            assign fq_w = {wquad_r, 3'(gf)};
            assign fq_r = {rquad_r, 3'(gf)};
            assign lvl_w = mq_pkg::PTR_W'(wptr_r[fq_w] - rptr_r[fq_w]);
            assign lvl_r = mq_pkg::PTR_W'(wptr_r[fq_r] - rptr_r[fq_r]);
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    af_r[gf] <= 1'b1;
                    ae_r[gf] <= 1'b0;
                end
                else
                begin
                    af_r[gf] <= (lvl_w < mq_pkg::PTR_W'(mq_pkg::QDEPTH_LVL - {1'b0, thr_r}));
                    ae_r[gf] <= (lvl_r > {1'b0, thr_r});
                end
            end
        end
    endgenerate

    assign almost_full_bus = af_r;
    assign almost_empty_bus = ae_r;

    // AXI4-Lite slave: threshold register and status
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic aw_go;
    logic [31:0] status;

    assign aw_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_awready = aw_go;
    assign s_axi_wready = aw_go;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    always_comb
    begin
        status = '0;
        status[mq_pkg::ST_WQ_LSB +: mq_pkg::QW] = wq_cur_r;
        status[mq_pkg::ST_RQ_LSB +: mq_pkg::QW] = rq_cur_r;
        status[mq_pkg::ST_NULL_BIT] = rq_null_r;
        status[mq_pkg::ST_FULL_BIT] = w_full;
        status[mq_pkg::ST_VALID_BIT] = out_valid_r;
        status[mq_pkg::ST_WCHG_LSB +: 2] = wchg_r;
        status[mq_pkg::ST_RCHG_LSB +: 2] = rchg_r;
        status[mq_pkg::ST_OCC_LSB +: mq_pkg::OCC_W] = occ_r;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            thr_r <= mq_pkg::THR_RST;
            bvalid_r <= 1'b0;
            bresp_r <= mq_pkg::RESP_OKAY;
        end
        else if (aw_go)
        begin
            bvalid_r <= 1'b1;
            if (s_axi_awaddr == mq_pkg::REG_THRESH)
            begin
                bresp_r <= mq_pkg::RESP_OKAY;
                if (s_axi_wstrb[0])
                begin
                    thr_r <= s_axi_wdata[mq_pkg::THR_W-1:0];
                end
            end
            else if (s_axi_awaddr == mq_pkg::REG_STATUS)
            begin
                bresp_r <= mq_pkg::RESP_OKAY;
            end
            else
            begin
                bresp_r <= mq_pkg::RESP_SLVERR;
            end
        end
        else if (s_axi_bready)
        begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rvalid_r <= 1'b0;
            rresp_r <= mq_pkg::RESP_OKAY;
            rdata_r <= '0;
        end
        else if (s_axi_arvalid && !rvalid_r)
        begin
            rvalid_r <= 1'b1;
            case (s_axi_araddr)
                mq_pkg::REG_THRESH:
                begin
                    rdata_r <= {28'h0000000, thr_r};
                    rresp_r <= mq_pkg::RESP_OKAY;
                end
                mq_pkg::REG_STATUS:
                begin
                    rdata_r <= status;
                    rresp_r <= mq_pkg::RESP_OKAY;
                end
                default:
                begin
                    rdata_r <= '0;
                    rresp_r <= mq_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end
endmodule // multi_queue_port_select
`default_nettype wire

// File: verification/mq_checker.sv
// Port assertions for the multi-queue port select block
`default_nettype none
module mq_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic output_enable_n,
    input wire logic read_data_oe_n,
    input wire logic [mq_pkg::DW-1:0] read_data,
    input wire logic output_valid_n,
    input wire logic read_en_n,
    input wire logic queue_full_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [mq_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    chk_oe_follow:
        assert property (!$past(sys_rst) |-> read_data_oe_n == $past(output_enable_n))
        else $error("oe_n not following output enable");
    chk_idle_hold:
        assert property (!$past(sys_rst) && output_valid_n |-> $stable(read_data))
        else $error("read data moved while not valid");
    chk_word_hold:
        assert property (!output_valid_n && read_en_n |=> !output_valid_n && $stable(read_data))
        else $error("unread word lost");
    chk_load_valid:
        assert property (!$past(sys_rst) && $changed(read_data) |-> !output_valid_n)
        else $error("word loaded without valid");
    chk_reset_flags:
        assert property ($past(sys_rst) |-> queue_full_n && output_valid_n && read_data_oe_n)
        else $error("flags wrong after reset");
    chk_b_answer:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> s_axi_bvalid)
        else $error("write response late");
    chk_r_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    chk_unmapped_read:
        assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:3] != 5'h00
            |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule // mq_checker
bind multi_queue_port_select mq_checker i_chk (.*);
`default_nettype wire

// File: verification/mq_read_host.sv
// Read-side host model: drains the output register and logs words
`default_nettype none
module mq_read_host (
    input wire logic clk,
    input wire logic drain,
    input wire logic output_valid_n,
    input wire logic [mq_pkg::DW-1:0] read_data,
    output logic read_en_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [mq_pkg::DW-1:0] got[$];
    initial read_en_n = 1'h1;
    always @(posedge clk)
    begin
        if (!read_en_n && !output_valid_n)
        begin
            got.push_back(read_data);
        end
        read_en_n <= !drain;
    end
endmodule // mq_read_host
`default_nettype wire

// File: verification/tb_multi_queue_port_select.sv
// Self-checking bench for the multi-queue port select block
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("ERROR %s exp %h got %h", nm, e, g); \
        end \
    end
module tb_multi_queue_port_select;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] ID = 3'h5;
    localparam logic [2:0] BADID = 3'h2;
    logic clk = 1'h0, sys_rst = 1'h1, drain = 1'h0;
    logic [mq_pkg::ID_W-1:0] device_identity_pins = ID;
    logic [mq_pkg::DW-1:0] write_data = '0, read_data, last_w;
    logic write_en_n = 1'h1, write_addr_latch_en = 1'h0, write_flag_strobe = 1'h0;
    logic read_addr_latch_en = 1'h0, read_flag_strobe = 1'h0, output_enable_n = 1'h0;
    logic [7:0] write_queue_addr_bus = '0, read_queue_addr_bus = '0;
    logic queue_full_n, read_en_n, read_data_oe_n, output_valid_n;
    logic [7:0] almost_full_bus, almost_empty_bus;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] seq = '0;
    logic [7:0] afe[4] = '{8'hff, 8'hfd, 8'hff, 8'hff};
    logic [7:0] aee[4] = '{8'h28, 8'h02, 8'h00, 8'h00};
    logic [mq_pkg::DW-1:0] expq[32][$];
    int mismatches = 0, n_checks = 0;
    multi_queue_port_select i_dut (.*);
    mq_read_host i_host (.*);
    always #12.5 clk = ~clk;
    task automatic wcyc(input logic lat, input logic [7:0] a, input logic en, input int q);
        @(posedge clk);
        write_addr_latch_en <= lat;
        write_queue_addr_bus <= a;
        write_en_n <= !en;
        write_data <= {20'h0, seq};
        if (en && q >= 0) expq[q].push_back({20'h0, seq});
        seq++;
    endtask
    task automatic fchk(input logic e);
        #1;
        `CHK("queue_full_n", e, queue_full_n)
    endtask
    task automatic rsel(input logic lat, input logic fs, input logic [7:0] a);
        @(posedge clk);
        read_addr_latch_en <= lat;
        read_flag_strobe <= fs;
        read_queue_addr_bus <= a;
        @(posedge clk);
        read_addr_latch_en <= 1'h0;
        read_flag_strobe <= 1'h0;
    endtask
    task automatic qsel(input logic [1:0] qd);
        @(posedge clk);
        write_flag_strobe <= 1'h1;
        write_queue_addr_bus <= {ID, 3'h0, qd};
        rsel(1'h0, 1'h1, {ID, 3'h0, qd});
        write_flag_strobe <= 1'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic rdrain(input int q);
        int n;
        n = expq[q].size();
        drain <= 1'h1;
        for (int i = 0; i < 80; i++)
        begin
            @(posedge clk);
            #1;
            if (i > 12 && i_host.got.size() >= n) break;
        end
        drain <= 1'h0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("words", n, i_host.got.size())
        for (int i = 0; i < n && i < i_host.got.size(); i++)
            `CHK("read_data", expq[q][i], i_host.got[i])
        if (n > 0) last_w = expq[q][n-1];
        expq[q] = {};
        i_host.got = {};
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        `CHK("rresp", er, s_axi_rresp)
        `CHK("rdata", e, s_axi_rdata & m)
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (2) @(posedge clk);
        wcyc(1'h1, {ID, 5'h03}, 1'h0, -1);
        repeat (2) wcyc(1'h0, 8'h00, 1'h0, -1);
        repeat (4) wcyc(1'h0, 8'h00, 1'h1, 3);
        wcyc(1'h1, {ID, 5'h05}, 1'h1, 3);
        repeat (2) wcyc(1'h0, 8'h00, 1'h1, 3);
        repeat (2) wcyc(1'h0, 8'h00, 1'h1, 5);
        wcyc(1'h1, {BADID, 5'h07}, 1'h1, 5);
        repeat (2) wcyc(1'h0, 8'h00, 1'h1, 5);
        wcyc(1'h1, {ID, 5'h09}, 1'h1, 5);
        repeat (2) wcyc(1'h0, 8'h00, 1'h0, -1);
        repeat (16) wcyc(1'h0, 8'h00, 1'h1, 9);
        wcyc(1'h0, 8'h00, 1'h1, -1);
        fchk(1'h0);
        wcyc(1'h1, {ID, 5'h0a}, 1'h0, -1);
        repeat (2)
        begin
            wcyc(1'h0, 8'h00, 1'h0, -1);
            fchk(1'h0);
        end
        wcyc(1'h0, 8'h00, 1'h0, -1);
        fchk(1'h1);
        for (int i = 0; i < 4; i++)
        begin
            qsel(2'(i));
            `CHK("almost_full_bus", afe[i], almost_full_bus)
            `CHK("almost_empty_bus", aee[i], almost_empty_bus)
        end
        output_enable_n <= 1'h1;
        rsel(1'h1, 1'h0, {ID, 5'h03});
        rdrain(3);
        `CHK("read_data_oe_n", 1'h1, read_data_oe_n)
        output_enable_n <= 1'h0;
        rsel(1'h1, 1'h0, {ID, 5'h05});
        rdrain(5);
        rsel(1'h1, 1'h0, {BADID, 5'h09});
        rdrain(31);
        rsel(1'h1, 1'h1, {ID, 5'h09});
        rdrain(31);
        `CHK("read_data", last_w, read_data)
        rsel(1'h1, 1'h0, {ID, 5'h09});
        repeat (6) @(posedge clk);
        rdrain(9);
        rsel(1'h1, 1'h0, {ID, 5'h0a});
        rdrain(10);
        `CHK("read_data", last_w, read_data)
        `CHK("output_valid_n", 1'h1, output_valid_n)
        axw(8'h00, 32'h0000_0005, 2'h0);
        axw(8'h04, 32'hffff_ffff, 2'h0);
        axr(8'h00, 32'h0000_000f, 32'h0000_0005, 2'h0);
        axr(8'h04, 32'h0001_001f, 32'h0000_000a, 2'h0);
        axr(8'h0c, 32'hffff_ffff, 32'h0000_0000, 2'h2);
        axw(8'h0c, 32'h0000_0001, 2'h2);
        end_of_test();
    end
endmodule // tb_multi_queue_port_select
`default_nettype wire
